//--- data_station_select_lines_bench.sv
`timescale 1ns/1ps
`include "station_regs.svh"
module data_station_select_lines_bench
    import station_pkg::*;
;
    logic clk;
    logic rst;
    logic psel, penable, pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic pready, pslverr, irq;
    logic [7:0] station_data_in, dev_data_out, sense_byte;
    logic [15:0] select_lines;
    logic dev_read_strobe, dev_write_strobe;
    int wstrobes = 0;
    logic [33:0] expq[$];
    logic [33:0] e;
    logic [7:0] b;
    int errors = 0;
    int comparisons = 0;
    integer seed = 32'h9aa9a2ba;

    station_select station_select_i (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .station_data_in(station_data_in), .select_lines(select_lines), .unit_lines(),
        .dev_data_out(dev_data_out), .dev_write_strobe(dev_write_strobe), .dev_read_strobe(dev_read_strobe),
        .sense_byte(sense_byte), .irq(irq));
    station_model station_model_i (.clk(clk), .rst(rst), .select_lines(select_lines),
        .sense_byte(sense_byte), .dev_read_strobe(dev_read_strobe), .station_data_in(station_data_in));

    always #2 clk = ~clk;

    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [32:0] seen, input logic [32:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic print_verdict;
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : print_verdict

    // e: {compare data, slave error, data}
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [33:0] ex);
        int n;
        expq.push_back(ex);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            errors++;
            print_verdict();
        end else begin
            psel <= 1'b0;
            penable <= 1'b0;
            // idle edge keeps each driver assignment to one per time step
            @(posedge clk);
        end
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 34'h0);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0, {2'b10, x});
    endtask : rd

    task automatic irq_is(input logic x);
        repeat (2) @(posedge clk);
        #1 check({32'h0, irq}, {32'h0, x});
    endtask : irq_is

    ////////////////////////////////////////////////////////////////////////////
    // good write commands seen on the station side
    always @(posedge clk) begin
        if (dev_write_strobe === 1'b1)
            wstrobes++;
    end

    // monitor: each answer retires the oldest expectation
    always @(posedge clk) begin
        if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
            e = expq.pop_front();
            if (e[33])
                check({pslverr, prdata}, e[32:0]);
            else
                check({pslverr, 32'h0}, {e[32], 32'h0});
        end
    end

    initial begin
        clk = 1'b0;
        rst <= 1'b1;
        {psel, penable, pwrite, paddr, pwdata} <= '0;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd(`OFS_SEL, 32'h0);
        rd(`OFS_STAT, 32'h0);
        for (int n = 1; n <= 8; n++) begin
            wr(`OFS_CMD, 32'h300 | (32'h1 << (8 - n)));
            rd(`OFS_SEL, n > 2 ? 32'h1 << (n - 1) : 32'h0);
            rd(`OFS_STAT, n == 5 ? 32'h8 : 32'h0);
            check({32'h0, station_model_i.close_set}, {32'h0, n == 6});
        end
        wr(`OFS_CMD, 32'h300);
        wr(`OFS_CMD, 32'h4FF);
        rd(`OFS_SEL, 32'h30000);
        wr(`OFS_SEL, 32'hFFFF);
        rd(`OFS_SEL, 32'h30000);
        apb(1'b0, 8'h20, 32'h0, {2'b11, 32'h0});
        $display("select lines done");
        // parity fault: byte 01 with bit 11 set has even ones
        wr(`OFS_CMD, 32'hA01);
        rd(`OFS_SEL, 32'h30080);
        rd(`OFS_COND, 32'h80);
        rd(`OFS_IRQ_STAT, 32'h1);
        wr(`OFS_IRQ_MASK, 32'h1);
        irq_is(1'b1);
        wr(`OFS_IRQ_STAT, 32'h1);
        irq_is(1'b0);
        // the refused write still left busy set
        wr(`OFS_CMD, 32'h308);
        rd(`OFS_STAT, 32'h1);
        check({32'h0, station_model_i.sense_needed}, 33'h1);
        check({32'h0, station_model_i.rec_len_err}, 33'h0);
        wr(`OFS_COND, 32'h0);
        rd(`OFS_STAT, 32'h9);
        check({32'h0, station_model_i.rec_len_err}, 33'h1);
        wr(`OFS_CMD, 32'h300);
        $display("parity done");
        repeat (4) begin
            b = 8'($random(seed));
            wr(`OFS_CMD, {20'h0, ~^b, 3'b010, b});
            rd(`OFS_DOUT, {24'h0, b});
        end
        rd(`OFS_STAT, 32'h1);
        check(33'(wstrobes), 33'h4);
        wr(`OFS_CMD, 32'h100);
        rd(`OFS_DIN, 32'h5A);
        check({25'h0, station_model_i.reads_seen}, 33'h1);
        rd(`OFS_IRQ_STAT, 32'h4);
        $display("data transfer done");
        // control bits combined in one command
        wr(`OFS_CMD, 32'h040);
        wr(`OFS_CMD, 32'h018);
        rd(`OFS_STAT, 32'h6);
        rd(`OFS_IRQ_STAT, 32'h6);
        wr(`OFS_IRQ_MASK, 32'h2);
        irq_is(1'b1);
        wr(`OFS_CMD, 32'h0A0);
        rd(`OFS_STAT, 32'h0);
        wr(`OFS_IRQ_STAT, 32'h7);
        irq_is(1'b0);
        rd(`OFS_IRQ_STAT, 32'h0);
        $display("control done");
        print_verdict();
    end
endmodule : data_station_select_lines_bench

//--- odd_parity_check.sv
`timescale 1ns/1ps
module odd_parity_check (
    // byte and its parity bit
    input wire logic [7:0] data,
    input wire logic par,
    // high when the count of ones including parity is even
    output logic bad
);
    logic [8:0] chain;

    assign chain[0] = par;
    genvar i;
    generate
        for (i = 0; i < 8; i = i + 1) begin : g_xor
            assign chain[i + 1] = chain[i] ^ data[i];
        end
    endgenerate
    assign bad = ~chain[8];
endmodule : odd_parity_check

//--- station_model.sv
`timescale 1ns/1ps
`include "station_regs.svh"
module station_model
    import station_pkg::*;
#(
    parameter logic [7:0] READ_BYTE = 8'h5A
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // attachment side
    input wire logic [15:0] select_lines,
    input wire logic [7:0] sense_byte,
    input wire logic dev_read_strobe,
    output logic [7:0] station_data_in
);
    logic sense_needed;
    logic rec_len_err;
    logic close_set;
    logic [7:0] reads_seen;

    // byte offered to every read command
    assign station_data_in = READ_BYTE;

    // abnormal report means the registers must be sensed
    always_ff @(posedge clk) begin
        sense_needed <= rst ? 1'b0 : select_lines[`LINE_SENSE - 1];
        rec_len_err <= rst ? 1'b0 : select_lines[`LINE_SENSE - 1] && sense_byte == 8'h00;
        close_set <= rst ? 1'b0 : select_lines[`LINE_CLOSE_SET - 1];
        reads_seen <= rst ? 8'h00 : reads_seen + {7'h00, dev_read_strobe};
    end
endmodule : station_model

//--- station_pkg.sv
package station_pkg;
    typedef enum logic [2:0] {
        GRP_CONTROL = 3'h0,
        GRP_READ = 3'h1,
        GRP_WRITE = 3'h2,
        GRP_SEL_LOW = 3'h3,
        GRP_SEL_HIGH = 3'h4
    } cmd_grp_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_ANSWER = 2'h1,
        ST_DONE = 2'h3
    } apb_st_t;
endpackage : station_pkg

//--- station_regs.svh
// Behaviour
// - select line 3 high tells the station it is in the wrong mode for data
// - select line 4 high is a normal acknowledgement without error
// - select line 5 high reports an abnormal condition; station reads the sense byte
// - line 5 high with no other condition bit set means record-length error
// - select line 6 tells the station to close the data set and advance
// - select line 7 high marks the last transferred record as end of job
// - select line 8 rises when outbound bus data fails its parity check
// - lines 9 to 16 stay low; lines 1 and 2 are spares, held low
`ifndef STATION_REGS_SVH
`define STATION_REGS_SVH

////////////////////////////////////////////////////////////////////////////////
// register byte offsets
`define OFS_CMD 8'h00
`define OFS_SEL 8'h04
`define OFS_STAT 8'h08
`define OFS_IRQ_STAT 8'h0C
`define OFS_IRQ_MASK 8'h10
`define OFS_COND 8'h14
`define OFS_DIN 8'h18
`define OFS_DOUT 8'h1C

////////////////////////////////////////////////////////////////////////////////
// command word fields
`define CMD_DATA_LSB 0
`define CMD_DATA_MSB 7
`define CMD_GRP_LSB 8
`define CMD_GRP_MSB 10
`define CMD_PAR_BIT 11

// control data bits, bit 0 is the most significant bit of the byte
`define CTL_RESET_REQ 0
`define CTL_ENABLE_INT 1
`define CTL_DISABLE_INT 2
`define CTL_REMOVE_BUSY 3
`define CTL_SET_REQ 4

// select line numbers (line n sits in bit n-1)
`define LINE_MODE_ERR 3
`define LINE_ACK 4
`define LINE_SENSE 5
`define LINE_CLOSE_SET 6
`define LINE_FINAL_REC 7
`define LINE_PARITY 8

// status bits
`define STAT_BUSY 0
`define STAT_INT_REQ 1
`define STAT_INT_EN 2
`define STAT_REC_LEN 3

// interrupt events
`define EV_PARITY 0
`define EV_INT_REQ 1
`define EV_READ 2
`define EV_COUNT 3

// condition byte bit set by the parity checker
`define COND_PARITY 7

// reset values
`define RST_SEL 16'h0000
`define RST_COND 8'h00
`define RST_MASK 3'h0

`endif

//--- station_select.sv
`timescale 1ns/1ps
`include "station_regs.svh"
module station_select
    import station_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // station side
    input wire logic [7:0] station_data_in,
    output logic [15:0] select_lines,
    output logic [1:0] unit_lines,
    output logic [7:0] dev_data_out,
    output logic dev_write_strobe,
    output logic dev_read_strobe,
    output logic [7:0] sense_byte,
    // interrupt
    output logic irq
);
    apb_st_t st;
    logic wr_done;
    logic mapped;
    logic cmd_wr;
    cmd_grp_t grp;
    logic [7:0] cdata;
    logic par_bad;
    logic par_err;
    logic [15:0] next_sel;
    logic [1:0] next_unit;
    logic busy;
    logic int_req;
    logic int_en;
    logic rec_len;
    logic [2:0] irq_stat;
    logic [2:0] irq_mask;
    logic [2:0] events;
    logic [7:0] din;
    logic int_req_rise;

    ////////////////////////////////////////////////////////////////////////////
    // apb: one wait state so read data leaves a flip-flop
    always_comb begin
        case (paddr)
            `OFS_CMD, `OFS_SEL, `OFS_STAT, `OFS_IRQ_STAT, `OFS_IRQ_MASK, `OFS_COND, `OFS_DIN, `OFS_DOUT: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st <= ST_IDLE;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            case (st)
                ST_IDLE: begin
                    if (psel && penable) begin
                        st <= ST_ANSWER;
                        pready <= 1'b1;
                        pslverr <= ~mapped;
                    end
                end
                ST_ANSWER: begin
                    st <= ST_DONE;
                    pready <= 1'b0;
                    pslverr <= 1'b0;
                end
                ST_DONE: begin
                    st <= ST_IDLE;
                end
                default: begin
                    st <= ST_IDLE;
                    pready <= 1'b0;
                    pslverr <= 1'b0;
                end
            endcase
        end
    end

    // writes take effect only at the completing edge
    assign wr_done = psel && penable && pready && pwrite && mapped;
    assign cmd_wr = wr_done && (paddr == `OFS_CMD);
    assign grp = cmd_grp_t'(pwdata[`CMD_GRP_MSB:`CMD_GRP_LSB]);
    // byte bit 0 is the msb, as on the host bus
    assign cdata = pwdata[`CMD_DATA_MSB:`CMD_DATA_LSB];

    always_ff @(posedge clk) begin
        if (rst) begin
            prdata <= 32'h00000000;
        end else if (psel && penable && !pready && !pwrite) begin
            case (paddr)
                `OFS_SEL: prdata <= {14'h0000, unit_lines, select_lines};
                `OFS_STAT: prdata <= {28'h0000000, rec_len, int_en, int_req, busy};
                `OFS_IRQ_STAT: prdata <= {29'h00000000, irq_stat};
                `OFS_IRQ_MASK: prdata <= {29'h00000000, irq_mask};
                `OFS_COND: prdata <= {24'h000000, sense_byte};
                `OFS_DIN: prdata <= {24'h000000, din};
                `OFS_DOUT: prdata <= {24'h000000, dev_data_out};
                default: prdata <= 32'h00000000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outbound parity, checked on write commands only
    odd_parity_check u_par (
        .data(cdata),
        .par(pwdata[`CMD_PAR_BIT]),
        .bad(par_bad)
    );
    assign par_err = cmd_wr && (grp == GRP_WRITE) && par_bad;

    ////////////////////////////////////////////////////////////////////////////
    // command group decode
    genvar n;
    generate
        for (n = 1; n <= 16; n = n + 1) begin : g_line
            if (n >= 3 && n <= 8) begin : g_used
                always_comb begin
                    next_sel[n - 1] = select_lines[n - 1];
                    if (cmd_wr && grp == GRP_SEL_LOW) begin
                        next_sel[n - 1] = cdata[8 - n];
                    end
                    if (n == `LINE_PARITY && par_err) begin
                        next_sel[n - 1] = 1'b1;
                    end
                end
            end else begin : g_idle
                // spares and lines 9 to 16 never rise, whatever is written
                always_comb begin
                    next_sel[n - 1] = 1'b0;
                end
            end
        end
    endgenerate
    assign next_unit = (cmd_wr && grp == GRP_SEL_HIGH) ? {cdata[0], cdata[1]} : unit_lines;

    always_ff @(posedge clk) begin
        if (rst) begin
            select_lines <= `RST_SEL;
            unit_lines <= 2'h0;
        end else begin
            select_lines <= next_sel;
            unit_lines <= next_unit;
        end
    end

    // station data transfers
    always_ff @(posedge clk) begin
        if (rst) begin
            dev_data_out <= 8'h00;
            dev_write_strobe <= 1'b0;
            dev_read_strobe <= 1'b0;
            din <= 8'h00;
        end else begin
            dev_write_strobe <= cmd_wr && grp == GRP_WRITE && !par_bad;
            dev_read_strobe <= cmd_wr && grp == GRP_READ;
            if (cmd_wr && grp == GRP_WRITE && !par_bad) begin
                dev_data_out <= cdata;
            end
            if (cmd_wr && grp == GRP_READ) begin
                din <= station_data_in;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // control group; bits combine, set request beats reset, disable beats enable
    always_ff @(posedge clk) begin
        if (rst) begin
            busy <= 1'b0;
            int_req <= 1'b0;
            int_en <= 1'b0;
        end else begin
            if (cmd_wr && (grp == GRP_READ || grp == GRP_WRITE)) begin
                busy <= 1'b1;
            end else if (cmd_wr && grp == GRP_CONTROL && cdata[7 - `CTL_REMOVE_BUSY]) begin
                busy <= 1'b0;
            end
            if (cmd_wr && grp == GRP_CONTROL && cdata[7 - `CTL_SET_REQ]) begin
                int_req <= 1'b1;
            end else if (cmd_wr && grp == GRP_CONTROL && cdata[7 - `CTL_RESET_REQ]) begin
                int_req <= 1'b0;
            end
            if (cmd_wr && grp == GRP_CONTROL && cdata[7 - `CTL_DISABLE_INT]) begin
                int_en <= 1'b0;
            end else if (cmd_wr && grp == GRP_CONTROL && cdata[7 - `CTL_ENABLE_INT]) begin
                int_en <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // condition byte the station senses; parity bit set by hardware wins
    always_ff @(posedge clk) begin
        if (rst) begin
            sense_byte <= `RST_COND;
        end else begin
            if (wr_done && paddr == `OFS_COND) begin
                sense_byte <= pwdata[7:0];
            end
            if (par_err) begin
                sense_byte[`COND_PARITY] <= 1'b1;
            end
        end
    end

    // sense line alone with an empty condition byte reads as record length
    assign rec_len = select_lines[`LINE_SENSE - 1] && (sense_byte == 8'h00);

    ////////////////////////////////////////////////////////////////////////////
    // interrupts: sticky, write one to clear, set beats clear
    assign int_req_rise = cmd_wr && grp == GRP_CONTROL && cdata[7 - `CTL_SET_REQ] && !int_req && int_en;
    assign events = {cmd_wr && grp == GRP_READ, int_req_rise, par_err};

    always_ff @(posedge clk) begin
        if (rst) begin
            irq_stat <= 3'h0;
            irq_mask <= `RST_MASK;
            irq <= 1'b0;
        end else begin
            if (wr_done && paddr == `OFS_IRQ_MASK) begin
                irq_mask <= pwdata[2:0];
            end
            if (wr_done && paddr == `OFS_IRQ_STAT) begin
                irq_stat <= (irq_stat & ~pwdata[2:0]) | events;
            end else begin
                irq_stat <= irq_stat | events;
            end
            irq <= |(irq_stat & irq_mask);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    sequence s_bad_write;
        cmd_wr && grp == GRP_WRITE && par_bad;
    endsequence

    sequence s_sel_low_write;
        cmd_wr && grp == GRP_SEL_LOW;
    endsequence

    sequence s_good_write;
        cmd_wr && grp == GRP_WRITE && !par_bad;
    endsequence

    sequence s_unit_write;
        cmd_wr && grp == GRP_SEL_HIGH;
    endsequence

    a_mode_err_line: assert property (@(posedge clk) disable iff (rst)
        s_sel_low_write |=> select_lines[`LINE_MODE_ERR - 1] == $past(cdata[8 - `LINE_MODE_ERR]))
        else $error("mode error line does not follow command");

    a_ack_line: assert property (@(posedge clk) disable iff (rst)
        s_sel_low_write |=> select_lines[`LINE_ACK - 1] == $past(cdata[8 - `LINE_ACK]))
        else $error("acknowledge line does not follow command");

    a_sense_stable: assert property (@(posedge clk) disable iff (rst)
        !(cmd_wr && grp == GRP_SEL_LOW) |=> $stable(select_lines[`LINE_SENSE - 1]))
        else $error("sense line changed without a select command");

    a_rec_len_flag: assert property (@(posedge clk) disable iff (rst)
        (psel && penable && !pready && !pwrite && paddr == `OFS_STAT)
        |=> prdata[`STAT_REC_LEN] == $past(select_lines[`LINE_SENSE - 1] && sense_byte == 8'h00))
        else $error("record length not flagged");

    a_close_final: assert property (@(posedge clk) disable iff (rst)
        s_sel_low_write |=> select_lines[`LINE_FINAL_REC - 1:`LINE_CLOSE_SET - 1] == $past({cdata[1], cdata[2]}))
        else $error("close or final record line wrong");

    a_parity_line: assert property (@(posedge clk) disable iff (rst)
        s_bad_write |=> select_lines[`LINE_PARITY - 1] && sense_byte[`COND_PARITY] && !dev_write_strobe)
        else $error("parity error not reported");

    a_idle_lines: assert property (@(posedge clk) disable iff (rst)
        select_lines[15:8] == 8'h00 && select_lines[1:0] == 2'h0)
        else $error("unused select line active");

    a_control_req: assert property (@(posedge clk) disable iff (rst)
        (cmd_wr && grp == GRP_CONTROL && cdata[7 - `CTL_SET_REQ]) |=> int_req ##1 int_req || $past(cmd_wr))
        else $error("set request not held");

    a_busy_clear: assert property (@(posedge clk) disable iff (rst)
        (cmd_wr && grp == GRP_CONTROL && cdata[7 - `CTL_REMOVE_BUSY]) |=> !busy)
        else $error("busy not removed");

    a_group_read: assert property (@(posedge clk) disable iff (rst)
        (cmd_wr && grp == GRP_READ) |=> dev_read_strobe && busy ##1 !dev_read_strobe)
        else $error("read command not decoded");

    a_final_line: assert property (@(posedge clk) disable iff (rst)
        s_sel_low_write |=> select_lines[`LINE_FINAL_REC - 1] == $past(cdata[8 - `LINE_FINAL_REC]))
        else $error("final record line does not follow command");

    a_sense_line: assert property (@(posedge clk) disable iff (rst)
        s_sel_low_write |=> select_lines[`LINE_SENSE - 1] == $past(cdata[8 - `LINE_SENSE]))
        else $error("sense line does not follow command");

    // line 8 is a level; only a select command drops it
    a_parity_held: assert property (@(posedge clk) disable iff (rst)
        (select_lines[`LINE_PARITY - 1] && !(cmd_wr && grp == GRP_SEL_LOW)) |=> select_lines[`LINE_PARITY - 1])
        else $error("parity line dropped without a select command");

    a_parity_sense: assert property (@(posedge clk) disable iff (rst)
        par_err |=> sense_byte[`COND_PARITY])
        else $error("parity bit missing from condition byte");

    a_write_strobe: assert property (@(posedge clk) disable iff (rst)
        s_good_write |=> dev_write_strobe && dev_data_out == $past(cdata) ##1 !dev_write_strobe)
        else $error("write command not decoded");

    // unit lines share the high group with the unused lines 9 to 16
    a_unit_select: assert property (@(posedge clk) disable iff (rst)
        s_unit_write |=> unit_lines == $past({cdata[0], cdata[1]}) && select_lines[15:8] == 8'h00)
        else $error("unit lines do not follow command");

    a_disable_int: assert property (@(posedge clk) disable iff (rst)
        (cmd_wr && grp == GRP_CONTROL && cdata[7 - `CTL_DISABLE_INT]) |=> !int_en)
        else $error("interrupt not disabled");

    a_enable_int: assert property (@(posedge clk) disable iff (rst)
        (cmd_wr && grp == GRP_CONTROL && cdata[7 - `CTL_ENABLE_INT] && !cdata[7 - `CTL_DISABLE_INT]) |=> int_en)
        else $error("interrupt not enabled");

    a_reset_req: assert property (@(posedge clk) disable iff (rst)
        (cmd_wr && grp == GRP_CONTROL && cdata[7 - `CTL_RESET_REQ] && !cdata[7 - `CTL_SET_REQ]) |=> !int_req)
        else $error("interrupt request not reset");

    // the station byte is captured when the read command commits
    a_read_data: assert property (@(posedge clk) disable iff (rst)
        (cmd_wr && grp == GRP_READ) |=> din == $past(station_data_in))
        else $error("read byte not captured");
endmodule : station_select
